// file: include/sag_pkg.sv
// Purpose: Shared constants and types for the segmented address generator.
// Assumes: One core clock, no software-visible registers.
// Notes:   Register numbers follow the usual sixteen-entry general register file.
package sag_pkg;
	localparam int unsigned ADDR_W      = 64;
	localparam int unsigned SEL_W       = 16;
	localparam int unsigned GPR_W       = 4;
	localparam int unsigned NUM_GPR     = 16;
	localparam logic [3:0]  GPR_STACK   = 4'h4;
	localparam logic [3:0]  GPR_FRAME   = 4'h5;
	localparam logic [63:0] ADDR_RST    = 64'h0;
	localparam int unsigned FP_OFF_LO   = 0;
	localparam int unsigned FP_OFF_W    = 32;
	localparam int unsigned FP_SEL_LO   = 32;

	typedef enum logic [2:0] {
		SAG_SEG_CODE,
		SAG_SEG_STACK,
		SAG_SEG_DATA,
		SAG_SEG_STRING,
		SAG_SEG_AUX1,
		SAG_SEG_AUX2
	} sag_seg_e;

	typedef enum logic [1:0] {
		SAG_REF_FETCH,
		SAG_REF_DATA,
		SAG_REF_PUSHPOP,
		SAG_REF_STRDST
	} sag_ref_e;

	typedef enum logic [1:0] {
		SAG_MODE_LEGACY,
		SAG_MODE_COMPAT,
		SAG_MODE_LONG64
	} sag_mode_e;

	typedef enum logic [1:0] {
		SAG_ASZ_16,
		SAG_ASZ_32,
		SAG_ASZ_64
	} sag_asz_e;

	typedef enum logic [1:0] {
		SAG_DISP_NONE,
		SAG_DISP_8,
		SAG_DISP_16,
		SAG_DISP_32
	} sag_disp_e;
endpackage

// file: sim/sag_mem_sink.sv
// Purpose: Memory side model that takes each valid linear address.
// Assumes: An address is taken at an enabled edge with valid high.
// Notes:   Keeps only the last address, so the bench can see what crossed.
`timescale 1ns/100ps
`default_nettype none
module sag_mem_sink (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        lin_valid,
	input  wire logic [63:0] lin_addr,
	output logic [63:0]      last_addr
);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_addr <= 64'h0;
		end else if (clk_en && lin_valid) begin
			last_addr <= lin_addr;
		end
	end
endmodule
`default_nettype wire

// file: sim/segmented_address_generation_tb.sv
// Purpose: Self-checking bench for the segmented address generator.
// Assumes: Results appear one enabled edge after a request.
// Notes:   Expected values are built here from segment and width rules.
`timescale 1ns/100ps
`default_nettype none
module segmented_address_generation_tb;
	logic               clk_sys, rst_b, clk_en, req_valid, addr_default32, addr_size_prefix;
	logic               wide_operand_bit, seg_ovr_valid, base_valid, index_valid, ptr_rel;
	logic               sel_from_mem, lin_valid, index_fault;
	logic [3:0]         base_idx, index_idx;
	logic [1:0]         scale_log2;
	logic [15:0]        sel_reg_val, sel_out;
	logic [31:0]        disp_val, far_off_out;
	logic [47:0]        far_ptr_mem;
	logic [63:0]        base_val, index_val, next_instr_pointer, lin_addr, eff_addr, last_addr;
	logic [63:0]        code_seg_base, stack_seg_base, data_seg_base, string_target_seg_base;
	logic [63:0]        aux_base_seg_one_base, aux_base_seg_two_base;
	sag_pkg::sag_ref_e  ref_kind;
	sag_pkg::sag_mode_e cpu_mode;
	sag_pkg::sag_seg_e  seg_ovr, seg_used;
	sag_pkg::sag_asz_e  addr_size;
	sag_pkg::sag_disp_e disp_kind;
	int                 fail_count, check_count;

	sag_addr_gen DUT (.clk_sys, .rst_b, .clk_en, .req_valid, .ref_kind, .cpu_mode, .addr_default32,
		.addr_size_prefix, .wide_operand_bit, .seg_ovr_valid, .seg_ovr, .base_valid, .base_idx,
		.base_val, .index_valid, .index_idx, .index_val, .scale_log2, .disp_kind, .disp_val,
		.ptr_rel, .next_instr_pointer, .code_seg_base, .stack_seg_base, .data_seg_base,
		.string_target_seg_base, .aux_base_seg_one_base, .aux_base_seg_two_base, .sel_from_mem,
		.sel_reg_val, .far_ptr_mem, .lin_valid, .lin_addr, .eff_addr, .seg_used, .addr_size,
		.index_fault, .sel_out, .far_off_out);
	sag_mem_sink SINK (.clk_sys, .rst_b, .clk_en, .lin_valid, .lin_addr, .last_addr);

	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// Outputs are read 1 ns after the edge so that edge's updates have landed.
	task automatic settle();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic t_seg();
		sag_pkg::sag_seg_e x [7] = '{sag_pkg::SAG_SEG_CODE, sag_pkg::SAG_SEG_AUX1,
			sag_pkg::SAG_SEG_STACK, sag_pkg::SAG_SEG_STRING, sag_pkg::SAG_SEG_STACK,
			sag_pkg::SAG_SEG_STACK, sag_pkg::SAG_SEG_DATA};
		for (int k = 0; k < 7; k++) begin
			@(posedge clk_sys);
			ref_kind <= (k < 4) ? sag_pkg::sag_ref_e'(k) : sag_pkg::SAG_REF_DATA;
			seg_ovr_valid <= (k < 4);
			seg_ovr <= sag_pkg::SAG_SEG_AUX1;
			base_idx <= (k < 4) ? 4'h3 : 4'(k);
			settle();
			if (k < 4) chk("seg", 64'(x[k]), 64'(seg_used));
			else chk("seg", 64'(x[k]), 64'(seg_used));
		end
	endtask

	task automatic t_legacy();
		logic [63:0] e;
		logic [63:0] d [4];
		d = '{64'h0, 64'hFFFF_FFFF_FFFF_FF80, 64'hFFFF_FFFF_FFFF_8080, 64'h0001_8080};
		for (int c = 0; c < 8; c++) begin
			@(posedge clk_sys);
			base_idx <= 4'h3;
			cpu_mode <= sag_pkg::sag_mode_e'(c[2]);
			{addr_default32, addr_size_prefix} <= c[1:0];
			scale_log2 <= c[1:0];
			disp_kind <= sag_pkg::sag_disp_e'(c[1:0]);
			settle();
			e = 64'hFFFF_FFF0 + (64'h30 << c[1:0]) + d[c[1:0]];
			e = (c[1] ^ c[0]) ? {32'h0, e[31:0]} : {48'h0, e[15:0]};
			chk("ea", e, eff_addr);
			chk("la", e + data_seg_base, lin_addr);
			chk("asz", 64'(c[1] ^ c[0]), 64'(addr_size));
		end
	endtask

	task automatic t_index();
		@(posedge clk_sys);
		index_idx <= sag_pkg::GPR_STACK;
		settle();
		chk("flt", 64'h1, 64'(index_fault));
		chk("vld", 64'h0, 64'(lin_valid));
		// A 32-bit address size keeps the whole 32-bit displacement.
		@(posedge clk_sys);
		{index_valid, base_valid, sel_from_mem} <= 3'h1;
		addr_size_prefix <= 1'h0;
		settle();
		chk("ea", 64'h0001_8080, eff_addr);
		chk("sel", 64'hABCD, 64'(sel_out));
		chk("off", 64'h1234_5678, 64'(far_off_out));
		@(posedge clk_sys);
		sel_from_mem <= 1'h0;
		settle();
		chk("sel", 64'h5A5A, 64'(sel_out));
		chk("sink", 64'h0002_8080, last_addr);
		@(posedge clk_sys);
		req_valid <= 1'h0;
		settle();
		chk("vld", 64'h0, 64'(lin_valid));
	endtask

	task automatic t_long();
		logic [63:0] b;
		logic [63:0] e;
		b = 64'h1234_5678_9ABC_DEF0;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_sys);
			cpu_mode <= sag_pkg::SAG_MODE_LONG64;
			req_valid <= 1'h1;
			ref_kind <= (c == 2) ? sag_pkg::SAG_REF_FETCH : sag_pkg::SAG_REF_DATA;
			{base_valid, index_valid, index_idx, base_idx, scale_log2} <= 12'hE53;
			{wide_operand_bit, addr_size_prefix} <= c[1:0];
			base_val <= b;
			disp_kind <= sag_pkg::SAG_DISP_8;
			disp_val <= 32'h0000_00FF;
			settle();
			e = (c[1] ? b : {32'h0, b[31:0]}) + 64'h17F;
			e = c[0] ? {32'h0, e[31:0]} : e;
			chk("ea", e, eff_addr);
			chk("la", e, lin_addr);
			chk("asz", c[0] ? 64'h1 : 64'h2, 64'(addr_size));
			chk("seg", (c == 2) ? 64'(sag_pkg::SAG_SEG_CODE) : 64'(sag_pkg::SAG_SEG_STACK),
				64'(seg_used));
		end
		@(posedge clk_sys);
		{ptr_rel, seg_ovr_valid, addr_size_prefix} <= 3'h6;
		seg_ovr <= sag_pkg::SAG_SEG_AUX2;
		disp_kind <= sag_pkg::SAG_DISP_32;
		disp_val <= 32'h8000_0000;
		next_instr_pointer <= 64'hFFFF_8000_0000_0010;
		settle();
		chk("ea", 64'hFFFF_7FFF_8000_0010, eff_addr);
		// With the enable low the last answer must stand although the inputs move.
		@(posedge clk_sys);
		clk_en <= 1'h0;
		disp_val <= 32'h0;
		settle();
		settle();
		chk("la", 64'hFFFF_7FFF_8010_0010, lin_addr);
	endtask

	task automatic end_of_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		{rst_b, clk_en, req_valid, addr_default32, addr_size_prefix, wide_operand_bit} = 6'h1C;
		{seg_ovr_valid, base_valid, index_valid, ptr_rel, sel_from_mem} = 5'h0C;
		{base_idx, index_idx, scale_log2} = 10'h0D8;
		{base_val, index_val, next_instr_pointer} = {64'hFFFF_FFF0, 64'h30, 64'h0};
		{code_seg_base, stack_seg_base, data_seg_base} = {64'h100, 64'h200, 64'h0001_0000};
		{string_target_seg_base, aux_base_seg_one_base} = {64'h400, 64'h500};
		aux_base_seg_two_base = 64'h0010_0000;
		{disp_val, sel_reg_val, far_ptr_mem} = {32'h0001_8080, 16'h5A5A, 48'hABCD_1234_5678};
		ref_kind = sag_pkg::SAG_REF_DATA;
		cpu_mode = sag_pkg::SAG_MODE_LEGACY;
		seg_ovr = sag_pkg::SAG_SEG_DATA;
		disp_kind = sag_pkg::SAG_DISP_NONE;
		fail_count = 0;
		check_count = 0;
		repeat (6) @(posedge clk_sys);
		chk("vld", 64'h0, 64'(lin_valid));
		rst_b <= 1'h1;
		t_seg();
		t_legacy();
		t_index();
		t_long();
		end_of_test();
	end
endmodule
`default_nettype wire

// file: src/sag_addr_gen.sv
// Purpose: Segment choice and effective/linear address formation for memory operands.
// Assumes: Decoder presents one operand per cycle; register values arrive with the request.
// Notes:   Limit, protection and paging checks live downstream.
`timescale 1ns/100ps
`default_nettype none
module sag_addr_gen (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	input  wire logic                  clk_en,
	input  wire logic                  req_valid,
	input  wire sag_pkg::sag_ref_e     ref_kind,
	input  wire sag_pkg::sag_mode_e    cpu_mode,
	input  wire logic                  addr_default32,
	input  wire logic                  addr_size_prefix,
	input  wire logic                  wide_operand_bit,
	input  wire logic                  seg_ovr_valid,
	input  wire sag_pkg::sag_seg_e     seg_ovr,
	input  wire logic                  base_valid,
	input  wire logic [3:0]            base_idx,
	input  wire logic [63:0]           base_val,
	input  wire logic                  index_valid,
	input  wire logic [3:0]            index_idx,
	input  wire logic [63:0]           index_val,
	input  wire logic [1:0]            scale_log2,
	input  wire sag_pkg::sag_disp_e    disp_kind,
	input  wire logic [31:0]           disp_val,
	input  wire logic                  ptr_rel,
	input  wire logic [63:0]           next_instr_pointer,
	input  wire logic [63:0]           code_seg_base,
	input  wire logic [63:0]           stack_seg_base,
	input  wire logic [63:0]           data_seg_base,
	input  wire logic [63:0]           string_target_seg_base,
	input  wire logic [63:0]           aux_base_seg_one_base,
	input  wire logic [63:0]           aux_base_seg_two_base,
	input  wire logic                  sel_from_mem,
	input  wire logic [15:0]           sel_reg_val,
	input  wire logic [47:0]           far_ptr_mem,
	output logic                       lin_valid,
	output logic [63:0]                lin_addr,
	output logic [63:0]                eff_addr,
	output sag_pkg::sag_seg_e          seg_used,
	output sag_pkg::sag_asz_e          addr_size,
	output logic                       index_fault,
	output logic [15:0]                sel_out,
	output logic [31:0]                far_off_out
);
	logic              lin_valid_q;
	logic              lin_valid_d;
	logic [63:0]       lin_addr_q;
	logic [63:0]       lin_addr_d;
	logic [63:0]       eff_addr_q;
	logic [63:0]       eff_addr_d;
	sag_pkg::sag_seg_e seg_q;
	sag_pkg::sag_seg_e seg_d;
	sag_pkg::sag_asz_e asz_q;
	sag_pkg::sag_asz_e asz_d;
	logic              idx_fault_q;
	logic              idx_fault_d;
	logic [15:0]       sel_q;
	logic [15:0]       sel_d;
	logic [31:0]       far_off_q;
	logic [31:0]       far_off_d;

	logic              long64;
	logic [63:0]       disp_ext;
	logic [63:0]       base_ext;
	logic [63:0]       index_ext;
	logic [63:0]       ea_raw;
	logic [63:0]       seg_base;
	logic [63:0]       ea_trunc;

	always_comb begin
		long64 = (cpu_mode == sag_pkg::SAG_MODE_LONG64);
		// Compatibility mode uses the legacy attribute table unchanged.
		if (long64) begin
			// No 16-bit addressing exists here; the prefix only drops to 32.
			asz_d = addr_size_prefix ? sag_pkg::SAG_ASZ_32 : sag_pkg::SAG_ASZ_64;
		end else begin
			// Prefix toggles the code segment default.
			asz_d = (addr_default32 ^ addr_size_prefix) ? sag_pkg::SAG_ASZ_32
			                                             : sag_pkg::SAG_ASZ_16;
		end

		// Displacement is sign-extended; absent means zero.
		unique case (disp_kind)
			sag_pkg::SAG_DISP_NONE: disp_ext = 64'h0;
			sag_pkg::SAG_DISP_8:    disp_ext = {{56{disp_val[7]}}, disp_val[7:0]};
			sag_pkg::SAG_DISP_16:   disp_ext = {{48{disp_val[15]}}, disp_val[15:0]};
			sag_pkg::SAG_DISP_32:   disp_ext = {{32{disp_val[31]}}, disp_val};
		endcase

		// In 64-bit mode register width is 32 unless the wide bit asks for the full 64.
		base_ext  = base_val;
		index_ext = index_val;
		if (long64 && !wide_operand_bit) begin
			base_ext  = {32'h0, base_val[31:0]};
			index_ext = {32'h0, index_val[31:0]};
		end
		// All sixteen register numbers are accepted as a base in 64-bit mode.
		if (!base_valid) begin
			base_ext = 64'h0;
		end
		// The stack pointer cannot be an index; such a request is flagged.
		idx_fault_d = req_valid && index_valid && (index_idx == sag_pkg::GPR_STACK);
		if (!index_valid || idx_fault_d) begin
			index_ext = 64'h0;
		end

		// Scale only touches a present index.
		if (ptr_rel && long64) begin
			ea_raw = next_instr_pointer + {{32{disp_val[31]}}, disp_val};
		end else begin
			ea_raw = disp_ext + base_ext + (index_ext << scale_log2);
		end

		// Segment choice: fixed defaults first, then overrides for plain data.
		unique case (ref_kind)
			sag_pkg::SAG_REF_FETCH:   seg_d = sag_pkg::SAG_SEG_CODE;
			sag_pkg::SAG_REF_PUSHPOP: seg_d = sag_pkg::SAG_SEG_STACK;
			sag_pkg::SAG_REF_STRDST:  seg_d = sag_pkg::SAG_SEG_STRING;
			sag_pkg::SAG_REF_DATA: begin
				if (seg_ovr_valid) begin
					seg_d = seg_ovr;
				end else if (base_valid && (base_idx == sag_pkg::GPR_STACK
				                            || base_idx == sag_pkg::GPR_FRAME)) begin
					seg_d = sag_pkg::SAG_SEG_STACK;
				end else begin
					seg_d = sag_pkg::SAG_SEG_DATA;
				end
			end
		endcase

		// Truncation happens before the base add so wrap matches the address size.
		unique case (asz_d)
			sag_pkg::SAG_ASZ_16: ea_trunc = {48'h0, ea_raw[15:0]};
			sag_pkg::SAG_ASZ_32: ea_trunc = {32'h0, ea_raw[31:0]};
			default:             ea_trunc = ea_raw;
		endcase

		unique case (seg_d)
			sag_pkg::SAG_SEG_CODE:   seg_base = code_seg_base;
			sag_pkg::SAG_SEG_STACK:  seg_base = stack_seg_base;
			sag_pkg::SAG_SEG_DATA:   seg_base = data_seg_base;
			sag_pkg::SAG_SEG_STRING: seg_base = string_target_seg_base;
			sag_pkg::SAG_SEG_AUX1:   seg_base = aux_base_seg_one_base;
			sag_pkg::SAG_SEG_AUX2:   seg_base = aux_base_seg_two_base;
			default:                 seg_base = 64'h0;
		endcase
		if (long64 && seg_d != sag_pkg::SAG_SEG_AUX1 && seg_d != sag_pkg::SAG_SEG_AUX2) begin
			seg_base = 64'h0;
		end

		eff_addr_d  = ea_trunc;
		lin_addr_d  = ea_trunc + seg_base;
		lin_valid_d = req_valid && !idx_fault_d;

		// Explicit selector from a register or the word after a far pointer's offset.
		sel_d     = sel_from_mem ? far_ptr_mem[sag_pkg::FP_SEL_LO +: sag_pkg::SEL_W]
		                         : sel_reg_val;
		far_off_d = far_ptr_mem[sag_pkg::FP_OFF_LO +: sag_pkg::FP_OFF_W];
	end

	// Results hold during clock-enable low so downstream sees a stable address.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lin_valid_q <= 1'h0;
			lin_addr_q  <= sag_pkg::ADDR_RST;
			eff_addr_q  <= sag_pkg::ADDR_RST;
			seg_q       <= sag_pkg::SAG_SEG_CODE;
			asz_q       <= sag_pkg::SAG_ASZ_16;
			idx_fault_q <= 1'h0;
			sel_q       <= 16'h0;
			far_off_q   <= 32'h0;
		end else if (clk_en) begin
			lin_valid_q <= lin_valid_d;
			lin_addr_q  <= lin_addr_d;
			eff_addr_q  <= eff_addr_d;
			seg_q       <= seg_d;
			asz_q       <= asz_d;
			idx_fault_q <= idx_fault_d;
			sel_q       <= sel_d;
			far_off_q   <= far_off_d;
		end
	end

	assign lin_valid   = lin_valid_q;
	assign lin_addr    = lin_addr_q;
	assign eff_addr    = eff_addr_q;
	assign seg_used    = seg_q;
	assign addr_size   = asz_q;
	assign index_fault = idx_fault_q;
	assign sel_out     = sel_q;
	assign far_off_out = far_off_q;

	// Segment choice checks. The request is sampled at one enabled edge and the
	// registered answer is judged at the next edge, whatever the enable does then.
	fetch_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && req_valid && ref_kind == sag_pkg::SAG_REF_FETCH
		|=> seg_used == sag_pkg::SAG_SEG_CODE)
		else $error("fetch not in code segment");
	stack_base_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && ref_kind == sag_pkg::SAG_REF_DATA && !seg_ovr_valid && base_valid
		&& base_idx == sag_pkg::GPR_FRAME |=> seg_used == sag_pkg::SAG_SEG_STACK)
		else $error("frame base not stack");
	sp_base_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && ref_kind == sag_pkg::SAG_REF_DATA && !seg_ovr_valid && base_valid
		&& base_idx == sag_pkg::GPR_STACK |=> seg_used == sag_pkg::SAG_SEG_STACK)
		else $error("stack pointer base not stack");
	data_default_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && ref_kind == sag_pkg::SAG_REF_DATA && !seg_ovr_valid && !base_valid
		|=> seg_used == sag_pkg::SAG_SEG_DATA)
		else $error("data default wrong");
	strdst_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && ref_kind == sag_pkg::SAG_REF_STRDST && seg_ovr_valid
		|=> seg_used == sag_pkg::SAG_SEG_STRING)
		else $error("string dest overridden");
	pushpop_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && ref_kind == sag_pkg::SAG_REF_PUSHPOP
		|=> seg_used == sag_pkg::SAG_SEG_STACK)
		else $error("push/pop not stack");
	override_data_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && ref_kind == sag_pkg::SAG_REF_DATA && seg_ovr_valid
		|=> seg_used == $past(seg_ovr))
		else $error("override ignored");

	// Selector and far pointer pass-through.
	sel_mem_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && sel_from_mem
		|=> sel_out == 16'($past(far_ptr_mem) >> sag_pkg::FP_SEL_LO))
		else $error("selector not taken from pointer");
	sel_reg_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !sel_from_mem
		|=> sel_out == $past(sel_reg_val))
		else $error("selector not taken from register");
	far_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en
		|=> far_off_out == 32'($past(far_ptr_mem)))
		else $error("far pointer offset wrong");

	// Address formation checks.
	no_sp_index_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && req_valid && index_valid && index_idx == sag_pkg::GPR_STACK
		|=> index_fault && !lin_valid)
		else $error("stack pointer index accepted");
	legacy_base_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && cpu_mode != sag_pkg::SAG_MODE_LONG64 && ref_kind == sag_pkg::SAG_REF_FETCH
		|=> lin_addr == eff_addr + $past(code_seg_base))
		else $error("legacy code base not added");
	flat_long_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && cpu_mode == sag_pkg::SAG_MODE_LONG64 && ref_kind != sag_pkg::SAG_REF_DATA
		|=> lin_addr == eff_addr)
		else $error("flat base not zero");
	aux_base_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && cpu_mode == sag_pkg::SAG_MODE_LONG64 && ref_kind == sag_pkg::SAG_REF_DATA
		&& seg_ovr_valid && seg_ovr == sag_pkg::SAG_SEG_AUX2
		|=> lin_addr == eff_addr + $past(aux_base_seg_two_base))
		else $error("auxiliary base not added");
	rel_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && cpu_mode == sag_pkg::SAG_MODE_LONG64 && ptr_rel && !addr_size_prefix
		|=> eff_addr == $past(next_instr_pointer) + 64'($signed($past(disp_val))))
		else $error("pointer-relative address wrong");
	no_asz16_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && cpu_mode == sag_pkg::SAG_MODE_LONG64
		|=> addr_size != sag_pkg::SAG_ASZ_16)
		else $error("16-bit size in 64-bit mode");
	trunc16_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		addr_size == sag_pkg::SAG_ASZ_16
		|-> eff_addr[63:16] == 48'h0)
		else $error("16-bit address not truncated");
	trunc_to32_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		addr_size == sag_pkg::SAG_ASZ_32
		|-> eff_addr[63:32] == 32'h0)
		else $error("32-bit address not truncated");

	// Handshake timing. The reset check has no disable so it watches the reset itself.
	valid_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && req_valid && !(index_valid && index_idx == sag_pkg::GPR_STACK)
		|=> lin_valid)
		else $error("valid not one cycle later");
	idle_invalid_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !req_valid
		|=> !lin_valid)
		else $error("valid without request");
	reset_invalid_a: assert property (@(posedge clk_sys)
		!rst_b
		|-> !lin_valid && lin_addr == sag_pkg::ADDR_RST)
		else $error("output valid during reset");
	hold_frozen_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!clk_en
		|=> $stable(lin_addr) && $stable(lin_valid))
		else $error("outputs moved with enable low");
endmodule
`default_nettype wire
